// ---- core/lbe_editor.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbe_editor (
   input  wire logic                         ref_clk_in,
   input  wire logic                         rst_n_in,
   input  wire logic                         btn_p_in,
   input  wire logic                         btn_e_in,
   input  wire logic                         btn_up_in,
   input  wire logic                         btn_down_in,
   input  wire logic                         enter_internal_ref_menu_in,
   input  wire logic                         enter_capture_menu_in,
   input  wire logic                         table_default_restore_in,
   input  wire logic                         sample_valid_in,
   input  wire logic [lbe_pkg::CUR_W-1:0]    loop_current_ua_in,
   output logic                              active_out,
   output logic [2:0]                        menu_state_out,
   output logic [2:0]                        sub_prompt_out,
   output logic [lbe_pkg::IDX_W-1:0]         sel_index_out,
   output logic [lbe_pkg::IDX_W-1:0]         point_count_out,
   output logic [3:0]                        edit_digit_out,
   output logic [lbe_pkg::VAL_W-1:0]         edit_value_out,
   output logic                              order_error_msg_out,
   output logic                              refused_out,
   output logic signed [lbe_pkg::VAL_W-1:0]  display_value_out,
   output logic                              display_valid_out
);
   localparam int N = lbe_pkg::MAX_PTS;
   localparam int IW = lbe_pkg::IDX_W;
   logic [lbe_pkg::CUR_W-1:0] cur_ff [N];
   logic [lbe_pkg::VAL_W-1:0] val_ff [N];
   logic [IW-1:0]             cnt_ff;
   logic [IW-1:0]             sel_ff;
   lbe_pkg::lbe_state_t       st_ff;
   lbe_pkg::lbe_sub_t         sub_ff;
   lbe_pkg::lbe_sub_t         last_ad_ff;
   logic                      internal_ff;
   logic [3:0]                dig_ff;
   logic [lbe_pkg::VAL_W-1:0] edit_ff;
   logic                      err_ff;
   logic                      ref_ff;
   logic [lbe_pkg::CUR_W-1:0] cand;
   logic                      ord_ok;
   logic [lbe_pkg::VAL_W-1:0] step;
   logic [IW-1:0]             last;
   logic                      ins_go;
   logic                      del_go;
   logic                      cur_go;
   logic                      val_go;

   assign last = cnt_ff - IW'(1);
   assign step = lbe_pkg::VAL_W'(1) << (dig_ff * 4);
   // Capture judges the live current at the press itself, so no stale copy can be stored.
   assign cand = (st_ff == lbe_pkg::ST_EDIT_CUR) ? edit_ff[lbe_pkg::CUR_W-1:0]
                                                 : loop_current_ua_in;
   // Both neighbours and the absolute window are checked together.
   always_comb begin
      ord_ok = (cand >= lbe_pkg::CUR_MIN_UA) && (cand <= lbe_pkg::CUR_MAX_UA);
      if (sel_ff != '0 && cand <= cur_ff[sel_ff - IW'(1)]) begin
         ord_ok = 1'b0;
      end
      if (sel_ff != last && cand >= cur_ff[sel_ff + IW'(1)]) begin
         ord_ok = 1'b0;
      end
   end
   assign ins_go = st_ff == lbe_pkg::ST_SELECT && sub_ff == lbe_pkg::SUB_ADD && btn_p_in
                   && cnt_ff != IW'(N);
   assign del_go = st_ff == lbe_pkg::ST_SELECT && sub_ff == lbe_pkg::SUB_DEL && btn_p_in
                   && cnt_ff > lbe_pkg::RST_COUNT;
   assign cur_go = (st_ff == lbe_pkg::ST_EDIT_CUR && btn_e_in) ||
                   (st_ff == lbe_pkg::ST_SELECT && sub_ff == lbe_pkg::SUB_CAPTURE && btn_p_in);
   assign val_go = st_ff == lbe_pkg::ST_EDIT_VAL && btn_e_in;

   // Table storage; inserted point copies the selected point, so its current equals that neighbour's until edited.
   generate
      for (genvar i = 0; i < N; i++) begin : g_pt
         always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               cur_ff[i] <= (i == 1) ? lbe_pkg::RST_CUR1 : lbe_pkg::RST_CUR0;
               val_ff[i] <= (i == 1) ? lbe_pkg::RST_VAL1 : lbe_pkg::RST_VAL0;
            end else if (table_default_restore_in) begin
               cur_ff[i] <= (i == 1) ? lbe_pkg::RST_CUR1 : lbe_pkg::RST_CUR0;
               val_ff[i] <= (i == 1) ? lbe_pkg::RST_VAL1 : lbe_pkg::RST_VAL0;
            end else if (ins_go && IW'(i) > sel_ff) begin
               cur_ff[i] <= cur_ff[(i == 0) ? 0 : i - 1];
               val_ff[i] <= val_ff[(i == 0) ? 0 : i - 1];
            end else if (del_go && IW'(i) >= sel_ff && i < N - 1) begin
               cur_ff[i] <= cur_ff[(i == N - 1) ? i : i + 1];
               val_ff[i] <= val_ff[(i == N - 1) ? i : i + 1];
            end else if (cur_go && ord_ok && IW'(i) == sel_ff) begin
               cur_ff[i] <= cand;
            end else if (val_go && IW'(i) == sel_ff) begin
               val_ff[i] <= edit_ff;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_ff <= lbe_pkg::RST_COUNT;
      end else if (table_default_restore_in) begin
         cnt_ff <= lbe_pkg::RST_COUNT;
      end else if (ins_go) begin
         cnt_ff <= cnt_ff + IW'(1);
      end else if (del_go) begin
         cnt_ff <= cnt_ff - IW'(1);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         err_ff <= 1'b0;
         ref_ff <= 1'b0;
      end else begin
         ref_ff <= (btn_p_in && st_ff == lbe_pkg::ST_SELECT && !ins_go && !del_go
                    && (sub_ff == lbe_pkg::SUB_ADD || sub_ff == lbe_pkg::SUB_DEL));
         if (cur_go) begin
            err_ff <= !ord_ok;
         end else if (btn_p_in || btn_e_in || btn_up_in || btn_down_in) begin
            err_ff <= 1'b0;
         end
      end
   end

   // Menu walk; the capture sub-function reads the live current, the typed ones never do.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff       <= lbe_pkg::ST_TOP;
         sub_ff      <= lbe_pkg::SUB_ADD;
         last_ad_ff  <= lbe_pkg::SUB_ADD;
         internal_ff <= 1'b0;
         sel_ff      <= '0;
         dig_ff      <= '0;
         edit_ff     <= '0;
      end else begin
         unique case (st_ff)
            lbe_pkg::ST_TOP: begin
               if (enter_internal_ref_menu_in || enter_capture_menu_in) begin
                  internal_ff <= enter_internal_ref_menu_in;
                  sub_ff      <= last_ad_ff;
                  st_ff       <= lbe_pkg::ST_MENU;
               end
            end
            lbe_pkg::ST_MENU: begin
               if (btn_e_in) begin
                  st_ff <= lbe_pkg::ST_TOP;
               end else if (btn_p_in) begin
                  sel_ff <= '0;
                  st_ff  <= lbe_pkg::ST_SELECT;
               end else if (btn_up_in || btn_down_in) begin
                  unique case (sub_ff)
                     lbe_pkg::SUB_ADD: sub_ff <= lbe_pkg::SUB_DEL;
                     lbe_pkg::SUB_DEL: sub_ff <= internal_ff ? lbe_pkg::SUB_CUR
                                                             : lbe_pkg::SUB_CAPTURE;
                     lbe_pkg::SUB_CUR: sub_ff <= lbe_pkg::SUB_VAL;
                     default:          sub_ff <= lbe_pkg::SUB_ADD;
                  endcase
               end
            end
            lbe_pkg::ST_SELECT: begin
               if (btn_e_in) begin
                  if (sub_ff == lbe_pkg::SUB_ADD || sub_ff == lbe_pkg::SUB_DEL) begin
                     last_ad_ff <= sub_ff;
                  end
                  st_ff <= lbe_pkg::ST_MENU;
               end else if (btn_up_in && sel_ff != last) begin
                  sel_ff <= sel_ff + IW'(1);
               end else if (btn_down_in && sel_ff != '0) begin
                  sel_ff <= sel_ff - IW'(1);
               end else if (btn_p_in) begin
                  dig_ff <= '0;
                  unique case (sub_ff)
                     lbe_pkg::SUB_CAPTURE: begin
                        if (ord_ok) begin
                           edit_ff <= val_ff[sel_ff];
                           st_ff   <= lbe_pkg::ST_EDIT_VAL;
                        end
                     end
                     lbe_pkg::SUB_CUR: begin
                        edit_ff <= lbe_pkg::VAL_W'(cur_ff[sel_ff]);
                        st_ff   <= lbe_pkg::ST_EDIT_CUR;
                     end
                     lbe_pkg::SUB_VAL: begin
                        edit_ff <= val_ff[sel_ff];
                        st_ff   <= lbe_pkg::ST_EDIT_VAL;
                     end
                     lbe_pkg::SUB_DEL: begin
                        if (del_go && sel_ff == last) begin
                           sel_ff <= sel_ff - IW'(1);
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            lbe_pkg::ST_EDIT_CUR, lbe_pkg::ST_EDIT_VAL: begin
               if (btn_e_in) begin
                  st_ff <= lbe_pkg::ST_SELECT;
               end else if (btn_p_in) begin
                  dig_ff <= (dig_ff == 4'(lbe_pkg::DIG_N - 1)) ? 4'h0 : dig_ff + 4'h1;
               end else if (btn_up_in) begin
                  edit_ff <= edit_ff + step;
               end else if (btn_down_in) begin
                  edit_ff <= edit_ff - step;
               end
            end
            default: st_ff <= lbe_pkg::ST_TOP;
         endcase
      end
   end

   // Segment search and interpolation over the selected table.
   lbe_interp_if ipi ();
   lbe_interp u_interp (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .ip         (ipi.slave)
   );
   logic [IW-1:0] seg;
   logic go_ff;
   always_comb begin
      seg = '0;
      for (int k = 1; k < N - 1; k++) begin
         if (IW'(k) < last && loop_current_ua_in >= cur_ff[k]) begin
            seg = IW'(k);
         end
      end
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         go_ff   <= 1'b0;
         ipi.dx     <= '0;
         ipi.span_x <= '0;
         ipi.span_y <= '0;
         ipi.base_y <= '0;
      end else begin
         go_ff <= sample_valid_in;
         if (sample_valid_in) begin
            ipi.dx     <= $signed({1'b0, loop_current_ua_in}) - $signed({1'b0, cur_ff[seg]});
            ipi.span_x <= $signed({1'b0, cur_ff[seg + IW'(1)]}) - $signed({1'b0, cur_ff[seg]});
            ipi.span_y <= $signed({val_ff[seg + IW'(1)][lbe_pkg::VAL_W-1], val_ff[seg + IW'(1)]})
                        - $signed({val_ff[seg][lbe_pkg::VAL_W-1], val_ff[seg]});
            ipi.base_y <= val_ff[seg];
         end
      end
   end
   assign ipi.start = go_ff;

   assign active_out          = st_ff != lbe_pkg::ST_TOP;
   assign menu_state_out      = st_ff;
   assign sub_prompt_out      = sub_ff;
   assign sel_index_out       = sel_ff;
   assign point_count_out     = cnt_ff;
   assign edit_digit_out      = dig_ff;
   assign edit_value_out      = edit_ff;
   assign order_error_msg_out = err_ff;
   assign refused_out         = ref_ff;
   assign display_value_out   = ipi.result;
   assign display_valid_out   = ipi.done;
endmodule
`default_nettype wire

// ---- core/lbe_interp.sv ----
`timescale 1ns/1ps
`default_nettype none
// Serial restoring divider; one result per DIV_STEPS + 1 cycles (load plus steps) keeps area small.
module lbe_interp (
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   lbe_interp_if.slave  ip
);
   localparam int PW = lbe_pkg::CUR_W + lbe_pkg::VAL_W + 2;
   logic [PW-1:0]  num_ff;
   logic [PW-1:0]  rem_ff;
   logic [PW-1:0]  quo_ff;
   logic [lbe_pkg::CUR_W:0] den_ff;
   logic           neg_ff;
   logic [5:0]     cnt_ff;
   logic           busy_ff;
   logic signed [lbe_pkg::VAL_W-1:0] base_ff;
   logic signed [PW-1:0] prod;
   logic [PW-1:0]  rem_sh;
   assign prod   = PW'(ip.dx) * PW'(ip.span_y);
   assign rem_sh = {rem_ff[PW-2:0], num_ff[PW-1]};
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         num_ff  <= '0;
         rem_ff  <= '0;
         quo_ff  <= '0;
         den_ff  <= '0;
         neg_ff  <= 1'b0;
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         base_ff <= '0;
         ip.done <= 1'b0;
         ip.result <= '0;
      end else begin
         ip.done <= 1'b0;
         if (ip.start && !busy_ff) begin
            neg_ff  <= prod[PW-1] ^ ip.span_x[lbe_pkg::CUR_W];
            num_ff  <= prod[PW-1] ? -prod : prod;
            den_ff  <= ip.span_x[lbe_pkg::CUR_W] ? -ip.span_x : ip.span_x;
            rem_ff  <= '0;
            quo_ff  <= '0;
            base_ff <= ip.base_y;
            cnt_ff  <= 6'(lbe_pkg::DIV_STEPS);
            busy_ff <= 1'b1;
         end else if (busy_ff) begin
            num_ff <= {num_ff[PW-2:0], 1'b0};
            if (rem_sh >= PW'(den_ff)) begin
               rem_ff <= rem_sh - PW'(den_ff);
               quo_ff <= {quo_ff[PW-2:0], 1'b1};
            end else begin
               rem_ff <= rem_sh;
               quo_ff <= {quo_ff[PW-2:0], 1'b0};
            end
            cnt_ff <= cnt_ff - 6'h01;
            if (cnt_ff == 6'h01) begin
               busy_ff <= 1'b0;
               ip.done <= 1'b1;
            end
         end
         if (ip.done) begin
            ip.result <= base_ff + (neg_ff ? -lbe_pkg::VAL_W'(quo_ff) : lbe_pkg::VAL_W'(quo_ff));
         end
      end
   end
endmodule
`default_nettype wire

// ---- core/lbe_interp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lbe_interp_if;
   logic                               start;
   logic signed [lbe_pkg::CUR_W:0]     dx;
   logic signed [lbe_pkg::CUR_W:0]     span_x;
   logic signed [lbe_pkg::VAL_W:0]     span_y;
   logic signed [lbe_pkg::VAL_W-1:0]   base_y;
   logic                               done;
   logic signed [lbe_pkg::VAL_W-1:0]   result;
   modport master (output start, dx, span_x, span_y, base_y, input done, result);
   modport slave  (input start, dx, span_x, span_y, base_y, output done, result);
endinterface
`default_nettype wire

// ---- core/lbe_pkg.sv ----
`default_nettype none
package lbe_pkg;
   localparam int MAX_PTS = 17;
   localparam int IDX_W   = 5;
   localparam int CUR_W   = 16;   // Loop current in microamps.
   localparam int VAL_W   = 20;   // Signed display value.
   localparam int DIG_N   = 5;
   localparam logic [CUR_W-1:0] CUR_MIN_UA = 16'h0ed8;  // 3800 uA.
   localparam logic [CUR_W-1:0] CUR_MAX_UA = 16'h5208;  // 21000 uA.
   localparam logic [CUR_W-1:0] RST_CUR0   = 16'h0fa0;  // 4000 uA.
   localparam logic [CUR_W-1:0] RST_CUR1   = 16'h4e20;  // 20000 uA.
   localparam logic [VAL_W-1:0] RST_VAL0   = 20'h00000;
   localparam logic [VAL_W-1:0] RST_VAL1   = 20'h003e8;  // 100.0 at one decimal.
   localparam logic [IDX_W-1:0] RST_COUNT  = 5'h02;
   localparam int DIV_STEPS = CUR_W + VAL_W + 2;  // One step per quotient bit.
   typedef enum logic [2:0] {
      SUB_ADD, SUB_DEL, SUB_CAPTURE, SUB_CUR, SUB_VAL
   } lbe_sub_t;
   typedef enum logic [2:0] {
      ST_TOP, ST_MENU, ST_SELECT, ST_EDIT_CUR, ST_EDIT_VAL
   } lbe_state_t;
endpackage
`default_nettype wire

// ---- testbench/lbe_editor_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbe_editor_asserts (
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic        btn_p_in,
   input wire logic        btn_e_in,
   input wire logic        btn_up_in,
   input wire logic        btn_down_in,
   input wire logic        enter_internal_ref_menu_in,
   input wire logic        enter_capture_menu_in,
   input wire logic        table_default_restore_in,
   input wire logic        sample_valid_in,
   input wire logic [2:0]  menu_state_out,
   input wire logic [2:0]  sub_prompt_out,
   input wire logic [4:0]  sel_index_out,
   input wire logic [4:0]  point_count_out,
   input wire logic        refused_out,
   input wire logic        display_valid_out
);
   // A press only counts as a lone P when no other button, menu entry or restore input is active in that cycle.
   wire only_p  = btn_p_in && !btn_e_in && !btn_up_in && !btn_down_in &&
                  !enter_internal_ref_menu_in && !enter_capture_menu_in &&
                  !table_default_restore_in;
   wire in_sel  = (menu_state_out == lbe_pkg::ST_SELECT);
   wire in_menu = (menu_state_out == lbe_pkg::ST_MENU);
   wire is_add  = (sub_prompt_out == lbe_pkg::SUB_ADD);
   wire is_del  = (sub_prompt_out == lbe_pkg::SUB_DEL);

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence add_press; in_sel && is_add && only_p; endsequence
   sequence del_press; in_sel && is_del && only_p; endsequence
   sequence result_due; ##[2:60] display_valid_out; endsequence

   count_range_a: assert property (point_count_out inside {[2:17]})
      else $error("point count left the two to seventeen span");
   add_step_a: assert property (add_press ##0 (point_count_out != 5'h11) |=>
      point_count_out == $past(point_count_out) + 5'h01) else $error("add did not grow count");
   add_full_a: assert property (add_press ##0 (point_count_out == 5'h11) |=>
      refused_out && point_count_out == 5'h11) else $error("add on full table not refused");
   del_step_a: assert property (del_press ##0 (point_count_out > 5'h02) |=>
      point_count_out == $past(point_count_out) - 5'h01) else $error("delete did not shrink");
   del_floor_a: assert property (del_press ##0 (point_count_out == 5'h02) |=>
      refused_out && point_count_out == 5'h02) else $error("delete at two not refused");
   refuse_cause_a: assert property (refused_out |-> $past(btn_p_in))
      else $error("refusal without a press");
   select_entry_a: assert property (in_menu && only_p |=> in_sel && sel_index_out == 5'h00)
      else $error("selection did not start at index zero");
   exit_select_a: assert property (in_sel && btn_e_in |=> in_menu)
      else $error("exit from selection missed the sub-menu");
   exit_menu_a: assert property (in_menu && btn_e_in |=> menu_state_out == lbe_pkg::ST_TOP)
      else $error("exit from sub-menu missed the top level");
   interp_due_a: assert property (sample_valid_in |-> result_due)
      else $error("no display result after a measurement");
endmodule

bind lbe_editor lbe_editor_asserts lbe_editor_asserts_i (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .btn_p_in(btn_p_in), .btn_e_in(btn_e_in),
   .btn_up_in(btn_up_in), .btn_down_in(btn_down_in),
   .enter_internal_ref_menu_in(enter_internal_ref_menu_in),
   .enter_capture_menu_in(enter_capture_menu_in),
   .table_default_restore_in(table_default_restore_in), .sample_valid_in(sample_valid_in),
   .menu_state_out(menu_state_out), .sub_prompt_out(sub_prompt_out),
   .sel_index_out(sel_index_out), .point_count_out(point_count_out),
   .refused_out(refused_out), .display_valid_out(display_valid_out));
`default_nettype wire

// ---- testbench/lbe_operator_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbe_operator_model (
   input  wire logic                  ref_clk_in,
   output logic [6:0]                 pulse_out,
   output logic                       sample_valid_out,
   output logic [lbe_pkg::CUR_W-1:0]  loop_current_ua_out
);
   initial begin
      pulse_out = 7'h00;
      sample_valid_out = 1'b0;
      loop_current_ua_out = lbe_pkg::RST_CUR0;
   end
   // Presses last one clock, as the upstream debouncer delivers them.
   task automatic press(input int unsigned k);
      @(posedge ref_clk_in);
      pulse_out <= 7'h01 << k;
      @(posedge ref_clk_in);
      pulse_out <= 7'h00;
   endtask
   // The source keeps the applied current; the strobe marks one fresh measurement of it.
   task automatic apply_current(input logic [lbe_pkg::CUR_W-1:0] ua);
      @(posedge ref_clk_in);
      loop_current_ua_out <= ua;
      sample_valid_out <= 1'b1;
      @(posedge ref_clk_in);
      sample_valid_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int unsigned K_P = 0, K_E = 1, K_UP = 2, K_DN = 3, K_INT = 4, K_CAP = 5, K_RST = 6;
   logic                ref_clk_in;
   logic                rst_n_in;
   logic [6:0]          pulse;
   logic                smp_valid;
   logic [15:0]         loop_ua;
   logic                active;
   logic [2:0]          state;
   logic [2:0]          sub;
   logic [4:0]          sel;
   logic [4:0]          count;
   logic [3:0]          edit_dig;
   logic [19:0]         edit_val;
   logic                order_err;
   logic                refused;
   logic signed [19:0]  disp;
   logic                disp_valid;
   int                  n_fail;
   int                  comparisons;
   int                  cycles;

   lbe_operator_model op_i (.ref_clk_in(ref_clk_in), .pulse_out(pulse),
      .sample_valid_out(smp_valid), .loop_current_ua_out(loop_ua));
   lbe_editor lbe_editor_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .btn_p_in(pulse[0]), .btn_e_in(pulse[1]), .btn_up_in(pulse[2]), .btn_down_in(pulse[3]),
      .enter_internal_ref_menu_in(pulse[4]), .enter_capture_menu_in(pulse[5]),
      .table_default_restore_in(pulse[6]), .sample_valid_in(smp_valid),
      .loop_current_ua_in(loop_ua), .active_out(active), .menu_state_out(state),
      .sub_prompt_out(sub), .sel_index_out(sel), .point_count_out(count),
      .edit_digit_out(edit_dig), .edit_value_out(edit_val), .order_error_msg_out(order_err),
      .refused_out(refused),
      .display_value_out(disp), .display_valid_out(disp_valid));

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic press(input int unsigned k);
      op_i.press(k);
      #1;
   endtask
   // The divider is slow, so wait on its strobe with a bound instead of a fixed delay.
   task automatic sample(input logic [15:0] ua);
      int n;
      op_i.apply_current(ua);
      #1;
      n = 0;
      while (disp_valid !== 1'b1 && n < 100) begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      chk_bit(disp_valid, 1'b1, "result strobe");
      @(posedge ref_clk_in);
      #1;
   endtask

   task automatic t_reset();
      chk(count, 2, "count after reset");
      chk(state, lbe_pkg::ST_TOP, "state after reset");
      chk_bit(active, 1'b0, "idle after reset");
   endtask
   task automatic t_add_full();
      press(K_INT);
      chk(sub, lbe_pkg::SUB_ADD, "first prompt");
      press(K_P);
      chk(state, lbe_pkg::ST_SELECT, "selection entered");
      chk(sel, 0, "selection index");
      chk(count, 2, "total shown");
      for (int i = 3; i <= 17; i++) begin
         press(K_P);
         chk(count, i, "count after add");
      end
      press(K_P);
      chk_bit(refused, 1'b1, "full refusal");
      chk(count, 17, "full count");
      @(posedge ref_clk_in);
      #1;
      chk_bit(refused, 1'b0, "refusal pulse ends");
      press(K_E);
      chk(sub, lbe_pkg::SUB_ADD, "prompt after add");
   endtask
   task automatic t_del_floor();
      press(K_UP);
      chk(sub, lbe_pkg::SUB_DEL, "delete prompt");
      press(K_P);
      for (int i = 16; i >= 2; i--) begin
         press(K_P);
         chk(count, i, "count after delete");
      end
      press(K_P);
      chk_bit(refused, 1'b1, "floor refusal");
      chk(count, 2, "floor count");
      press(K_E);
      chk(sub, lbe_pkg::SUB_DEL, "prompt after delete");
      press(K_E);
      chk(state, lbe_pkg::ST_TOP, "exit to top");
   endtask
   task automatic t_capture();
      press(K_RST);
      press(K_CAP);
      press(K_UP);
      chk(sub, lbe_pkg::SUB_CAPTURE, "capture prompt");
      press(K_P);
      sample(16'h5014);
      press(K_P);
      chk_bit(order_err, 1'b1, "order error shown");
      chk(state, lbe_pkg::ST_SELECT, "rejected capture stays");
      sample(16'h2ee0);
      chk(disp, 500, "table kept after rejection");
      sample(16'h0f3c);
      press(K_P);
      chk_bit(order_err, 1'b0, "valid capture");
      chk(state, lbe_pkg::ST_EDIT_VAL, "value entry");
      press(K_E);
      chk(state, lbe_pkg::ST_SELECT, "commit returns");
      press(K_E);
      press(K_E);
      chk(state, lbe_pkg::ST_TOP, "capture exit");
   endtask
   task automatic t_interp();
      press(K_RST);
      sample(16'h2ee0);
      chk(disp, 500, "mid segment");
      sample(16'h07d0);
      chk(disp, -125, "below first point");
      sample(16'h5dc0);
      chk(disp, 1250, "above last point");
   endtask

   task automatic t_typed();
      press(K_RST);
      press(K_INT);
      press(K_UP);
      chk(sub, lbe_pkg::SUB_CUR, "typed current prompt");
      press(K_P);
      press(K_P);
      chk(state, lbe_pkg::ST_EDIT_CUR, "current entry");
      chk(edit_val, lbe_pkg::RST_CUR0, "current shown");
      press(K_DN);
      press(K_E);
      chk_bit(order_err, 1'b0, "typed current accepted");
      press(K_UP);
      press(K_P);
      press(K_P);
      press(K_P);
      press(K_P);
      chk(edit_dig, 3, "digit moved");
      press(K_UP);
      press(K_E);
      chk_bit(order_err, 1'b1, "current above window");
      press(K_E);
      press(K_UP);
      chk(sub, lbe_pkg::SUB_VAL, "typed value prompt");
      press(K_P);
      press(K_UP);
      press(K_P);
      press(K_P);
      press(K_UP);
      press(K_E);
      press(K_E);
      press(K_E);
      chk(state, lbe_pkg::ST_TOP, "typed exit");
      sample(16'h4e20);
      chk(disp, lbe_pkg::RST_VAL1 + 20'h00010, "typed point used");
   endtask

   always #20 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      ref_clk_in = 1'b0;
      rst_n_in = 1'b0;
      n_fail = 0;
      comparisons = 0;
      cycles = 0;
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(posedge ref_clk_in);
      #1;
      t_reset();
      t_add_full();
      t_del_floor();
      t_capture();
      t_interp();
      t_typed();
      give_verdict();
   end
endmodule
`default_nettype wire
